// file: adc_path_pkg.sv
// Shared constants, register map, gain tables and carrier types for the channel path
package adc_path_pkg;
  localparam int DW = 14;
  localparam int NARROW_W = 9;
  localparam int PAIRS = 7;
  localparam int ORDER_LO = 12;
  localparam int ORDER_HI = 20;
  localparam int FRAME_BITS = 16;
  localparam int OFFS_SHIFT = 10;
  localparam int NS_SHIFT = DW - NARROW_W;

  localparam logic [7:0] REG_SPI_CTRL = 8'h00;
  localparam logic [7:0] REG_CORE_GAIN [4] = '{8'h2B, 8'h25, 8'h31, 8'h37};
  localparam logic [7:0] REG_FILT_GAIN [2] = '{8'h2C, 8'h32};
  localparam logic [7:0] REG_PAT_HI = 8'h3F;
  localparam logic [7:0] REG_PAT_LO = 8'h40;
  localparam logic [7:0] REG_GAIN_CTRL = 8'h42;
  localparam logic [7:0] REG_LATENCY = 8'h44;
  localparam logic [7:0] REG_FILT_CFG = 8'h60;
  localparam logic [7:0] REG_TEST_SEL = 8'h61;
  localparam logic [7:0] REG_STATUS = 8'h62;
  localparam logic [7:0] REG_OUT_MODE = 8'hF3;

  localparam int BIT_READOUT = 0;
  localparam int BIT_GAIN_EN = 3;
  localparam int BIT_BYPASS = 1;
  localparam int BIT_HIGHPASS = 0;
  localparam int BIT_ORDER20 = 1;
  localparam int BIT_OFFS_EN = 2;
  localparam int BIT_WIDE = 3;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [15:0] UNITY_Q14 = 16'h4000;
  localparam logic [15:0] RECIP_ORDER_LO = 16'h04EC;
  localparam logic [15:0] RECIP_ORDER_HI = 16'h030C;
  localparam logic [15:0] FG_DEF_40 = 16'h4CF2;
  localparam logic [15:0] FG_DEF_75 = 16'h4FA6;

  typedef struct packed {
    logic signed [DW-1:0] even;
    logic signed [DW-1:0] odd;
  } core_pair_t;

  typedef struct packed {
    logic [3:0] gain_step;
    logic gain_en;
    logic offs_en;
    logic test_en;
    logic [DW-1:0] pattern;
  } core_cfg_t;

  // Per-core gain, 0.5 dB per step in Q2.14; reserved steps fall back to unity
  function automatic logic [15:0] core_gain_q(input logic [3:0] step);
    case (step)
      4'h1: core_gain_q = 16'h43CB;
      4'h2: core_gain_q = 16'h47CF;
      4'h3: core_gain_q = 16'h4C10;
      4'h4: core_gain_q = 16'h5092;
      4'h5: core_gain_q = 16'h5558;
      4'h6: core_gain_q = 16'h5A67;
      4'h7: core_gain_q = 16'h5FC2;
      4'h8: core_gain_q = 16'h656F;
      4'h9: core_gain_q = 16'h6B71;
      4'hA: core_gain_q = 16'h71CF;
      4'hB: core_gain_q = 16'h788E;
      4'hC: core_gain_q = 16'h7FB2;
      default: core_gain_q = UNITY_Q14;
    endcase
  endfunction : core_gain_q

  function automatic logic [15:0] filt_gain_q(input logic [7:0] code, input logic bw75);
    case (code)
      8'h04: filt_gain_q = 16'h2CB6;
      8'h0C: filt_gain_q = 16'h3235;
      8'h14: filt_gain_q = 16'h35E2;
      8'h1C: filt_gain_q = 16'h390B;
      8'h24: filt_gain_q = 16'h3C6B;
      8'h2C: filt_gain_q = UNITY_Q14;
      8'h34: filt_gain_q = 16'h43CB;
      8'h3C: filt_gain_q = 16'h47CF;
      8'h44: filt_gain_q = 16'h4C10;
      8'h4C: filt_gain_q = 16'h5092;
      8'h54: filt_gain_q = 16'h5A67;
      default: filt_gain_q = bw75 ? FG_DEF_75 : FG_DEF_40;
    endcase
  endfunction : filt_gain_q

  function automatic logic signed [DW-1:0] clip(input logic signed [39:0] v);
    if (v > 40'sh00_0000_1FFF) clip = 14'h1FFF;
    else if (v < 40'shFF_FFFF_E000) clip = 14'h2000;
    else clip = v[DW-1:0];
  endfunction : clip

  function automatic logic signed [DW-1:0] scale(input logic signed [19:0] x,
                                                 input logic [15:0] g);
    logic signed [39:0] p;
    p = 40'(x) * 40'($signed({1'b0, g}));
    scale = clip(p >>> 14);
  endfunction : scale
endpackage : adc_path_pkg

// file: core_stage.sv
// One ADC core's offset correction, digital gain and test-pattern substitution
`timescale 1ns/1ps
`default_nettype none
module core_stage
  import adc_path_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sample_en,
  input wire logic signed [DW-1:0] raw,
  input wire core_cfg_t cfg,
  output logic signed [DW-1:0] core_out_ff
);
  localparam int ACC_W = DW + OFFS_SHIFT;

  // Leaky average of the raw data tracks the core's DC offset
  logic signed [ACC_W-1:0] acc_ff;
  wire logic signed [DW-1:0] offs_est = acc_ff[ACC_W-1 -: DW];
  wire logic signed [ACC_W-1:0] nxt_acc = acc_ff + ACC_W'(raw) - (acc_ff >>> OFFS_SHIFT);
  wire logic signed [DW-1:0] corrected = cfg.offs_en ? clip(40'(raw) - 40'(offs_est)) : raw;
  // Gain stage works on its own code, unaware of the filter gain
  wire logic signed [DW-1:0] gained =
    cfg.gain_en ? scale(20'(corrected), core_gain_q(cfg.gain_step)) : corrected;
  wire logic signed [DW-1:0] nxt_out = cfg.test_en ? cfg.pattern : gained;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_ff <= '0;
      core_out_ff <= '0;
    end else if (sample_en) begin
      acc_ff <= nxt_acc;
      core_out_ff <= nxt_out;
    end
  end
endmodule : core_stage
`default_nettype wire

// file: adc_channel_gain_filter_path.sv
// Dual-channel digital path: cores, decimation filter, noise shaping, DDR serializer, serial regs
// Operation
// - Each channel owns an independent path fed by its even and odd cores.
// - Every core has gain, offset correction and a test pattern that can replace data.
// - The decimation filter runs on the interleaved even/odd stream of one channel.
// - The filter is low-pass or high-pass; a higher order lowers ripple.
// - The filter can be bypassed to pass the full Nyquist band.
// - Noise shaping follows the filter and works only in 9-bit mode.
// - Each channel leaves as DDR pairs with its own output clock.
// - Filter is on after reset, gain 1.6 dB, or 1.9 dB at 75 MHz bandwidth.
// - Filter gain per channel from an 8-bit code, -3.1 to +3 dB.
// - With the filter bypassed the filter gain has no effect.
// - Each core gain is 0 to 6 dB in 0.5 dB steps.
// - Core gain codes sit in the upper nibble at 2B, 25, 31, 37.
// - Core gain and filter gain act independently and add.
// - Filter order is 12th or 20th, 12th after reset.
// - Bit D1 of register 44 bypasses the filter.
// - Bit D3 of register F3 selects 14-bit mode, else 9-bit mode.
`timescale 1ns/1ps
`default_nettype none
module adc_channel_gain_filter_path
  import adc_path_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sample_en,
  input wire core_pair_t [CHANNELS-1:0] ch_raw,
  input wire logic sclk,
  input wire logic sen_n,
  input wire logic sdata,
  output logic sdout,
  input wire logic noise_shape_en_pin,
  input wire logic noise_bw75_pin,
  output logic [CHANNELS-1:0][PAIRS-1:0] lvds_data,
  output logic [CHANNELS-1:0] lvds_clk
);
  localparam int NPINS = 5;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SEN = 1;
  localparam int PIN_SDATA = 2;
  localparam int PIN_NS_EN = 3;
  localparam int PIN_BW75 = 4;
  // Idle pin levels: serial clock and enable high, the rest low
  localparam logic [NPINS-1:0] PIN_IDLE = 5'h03;

  // ---------------- Pin synchronisers ----------------
  wire logic [NPINS-1:0] pins_in = {noise_bw75_pin, noise_shape_en_pin, sdata, sen_n, sclk};
  logic [NPINS-1:0] sync1_ff;
  logic [NPINS-1:0] sync2_ff;
  logic [NPINS-1:0] sync3_ff;
  logic [NPINS-1:0] pin_lvl_ff;
  wire logic [NPINS-1:0] pin_agree = ~(sync2_ff ^ sync3_ff);
  wire logic [NPINS-1:0] nxt_pin_lvl = (pin_agree & sync2_ff) | (~pin_agree & pin_lvl_ff);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // All stages start at the idle levels, so leaving reset gives no false serial edge
      sync1_ff <= PIN_IDLE;
      sync2_ff <= PIN_IDLE;
      sync3_ff <= PIN_IDLE;
      pin_lvl_ff <= PIN_IDLE;
    end else begin
      sync1_ff <= pins_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_lvl_ff <= nxt_pin_lvl;
    end
  end

  wire logic sclk_rise = nxt_pin_lvl[PIN_SCLK] & ~pin_lvl_ff[PIN_SCLK];
  wire logic sclk_fall = ~nxt_pin_lvl[PIN_SCLK] & pin_lvl_ff[PIN_SCLK];
  wire logic frame_on = ~pin_lvl_ff[PIN_SEN];
  wire logic bw75 = pin_lvl_ff[PIN_BW75];

  // ---------------- Serial register interface ----------------
  logic [FRAME_BITS-1:0] shift_ff;
  logic [4:0] bit_cnt_ff;
  logic [7:0] rd_shift_ff;
  logic [7:0] spi_ctrl_ff;
  logic [7:0] core_gain_ff [4];
  logic [7:0] filt_gain_ff [2];
  logic [5:0] pat_hi_ff;
  logic [7:0] pat_lo_ff;
  logic [7:0] gain_ctrl_ff;
  logic [7:0] latency_ff;
  logic [7:0] filt_cfg_ff;
  logic [3:0] test_sel_ff;
  logic [7:0] out_mode_ff;
  logic [7:0] status_w;
  logic [7:0] rd_data;

  wire logic [FRAME_BITS-1:0] nxt_shift = {shift_ff[FRAME_BITS-2:0], pin_lvl_ff[PIN_SDATA]};
  wire logic readout = spi_ctrl_ff[BIT_READOUT];
  wire logic last_bit = frame_on & sclk_rise & (bit_cnt_ff == 5'(FRAME_BITS - 1));
  wire logic addr_done = frame_on & sclk_rise & (bit_cnt_ff == 5'd7);
  // Readout mode blocks writes so a read frame cannot disturb state; control 0x00 stays writable
  wire logic wr_stb = last_bit & (~readout | (nxt_shift[15:8] == REG_SPI_CTRL));
  wire logic [7:0] wr_addr = nxt_shift[15:8];
  wire logic [7:0] wr_data = nxt_shift[7:0];
  wire logic [7:0] rd_addr = nxt_shift[7:0];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shift_ff <= '0;
      bit_cnt_ff <= '0;
      rd_shift_ff <= '0;
      sdout <= 1'b0;
    end else begin
      if (!frame_on) begin
        bit_cnt_ff <= '0;
      end else if (sclk_rise) begin
        shift_ff <= nxt_shift;
        bit_cnt_ff <= bit_cnt_ff + 5'd1;
      end
      if (addr_done && readout) begin
        rd_shift_ff <= rd_data;
      end else if (frame_on && sclk_fall && bit_cnt_ff >= 5'd8) begin
        sdout <= rd_shift_ff[7];
        rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      spi_ctrl_ff <= REG_RESET;
      for (int i = 0; i < 4; i++) core_gain_ff[i] <= REG_RESET;
      for (int i = 0; i < 2; i++) filt_gain_ff[i] <= REG_RESET;
      pat_hi_ff <= '0;
      pat_lo_ff <= REG_RESET;
      gain_ctrl_ff <= REG_RESET;
      latency_ff <= REG_RESET;
      filt_cfg_ff <= REG_RESET;
      test_sel_ff <= '0;
      out_mode_ff <= REG_RESET;
    end else if (wr_stb) begin
      if (wr_addr == REG_SPI_CTRL) spi_ctrl_ff <= wr_data;
      for (int i = 0; i < 4; i++) begin
        if (wr_addr == REG_CORE_GAIN[i]) core_gain_ff[i] <= wr_data;
      end
      for (int i = 0; i < 2; i++) begin
        if (wr_addr == REG_FILT_GAIN[i]) filt_gain_ff[i] <= wr_data;
      end
      if (wr_addr == REG_PAT_HI) pat_hi_ff <= wr_data[5:0];
      if (wr_addr == REG_PAT_LO) pat_lo_ff <= wr_data;
      if (wr_addr == REG_GAIN_CTRL) gain_ctrl_ff <= wr_data;
      if (wr_addr == REG_LATENCY) latency_ff <= wr_data;
      if (wr_addr == REG_FILT_CFG) filt_cfg_ff <= wr_data;
      if (wr_addr == REG_TEST_SEL) test_sel_ff <= wr_data[3:0];
      if (wr_addr == REG_OUT_MODE) out_mode_ff <= wr_data;
    end
  end

  always_comb begin
    rd_data = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (rd_addr == REG_CORE_GAIN[i]) rd_data = core_gain_ff[i];
    end
    for (int i = 0; i < 2; i++) begin
      if (rd_addr == REG_FILT_GAIN[i]) rd_data = filt_gain_ff[i];
    end
    case (rd_addr)
      REG_SPI_CTRL: rd_data = spi_ctrl_ff;
      REG_PAT_HI: rd_data = {2'b00, pat_hi_ff};
      REG_PAT_LO: rd_data = pat_lo_ff;
      REG_GAIN_CTRL: rd_data = gain_ctrl_ff;
      REG_LATENCY: rd_data = latency_ff;
      REG_FILT_CFG: rd_data = filt_cfg_ff;
      REG_TEST_SEL: rd_data = {4'h0, test_sel_ff};
      REG_STATUS: rd_data = status_w;
      REG_OUT_MODE: rd_data = out_mode_ff;
      default: ;
    endcase
  end

  // ---------------- Decoded controls ----------------
  wire logic bypass = latency_ff[BIT_BYPASS];
  wire logic highpass = filt_cfg_ff[BIT_HIGHPASS];
  wire logic order20 = filt_cfg_ff[BIT_ORDER20];
  wire logic wide_resolution_select = out_mode_ff[BIT_WIDE];
  // Shaping is refused in 14-bit mode whatever the pin says
  wire logic ns_active = pin_lvl_ff[PIN_NS_EN] & ~wide_resolution_select & ~bypass;
  wire logic gain_common = gain_ctrl_ff[BIT_GAIN_EN];
  wire logic [5:0] order_n = order20 ? 6'(ORDER_HI) : 6'(ORDER_LO);
  wire logic [15:0] recip = order20 ? RECIP_ORDER_HI : RECIP_ORDER_LO;

  logic sample_d1_ff;
  logic sample_d2_ff;
  logic sample_d3_ff;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sample_d1_ff <= 1'b0;
      sample_d2_ff <= 1'b0;
      sample_d3_ff <= 1'b0;
    end else begin
      sample_d1_ff <= sample_en;
      sample_d2_ff <= sample_d1_ff;
      sample_d3_ff <= sample_d2_ff;
    end
  end

  // ---------------- Output sequencer shared by both channels ----------------
  logic [1:0] phase_ff;
  logic active_ff;
  logic two_words_ff;
  wire logic seq_last = active_ff & (phase_ff == (two_words_ff ? 2'd3 : 2'd1));

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase_ff <= '0;
      active_ff <= 1'b0;
      two_words_ff <= 1'b0;
    end else if (sample_d3_ff) begin
      phase_ff <= '0;
      active_ff <= 1'b1;
      two_words_ff <= bypass;
    end else if (seq_last) begin
      active_ff <= 1'b0;
    end else if (active_ff) begin
      phase_ff <= phase_ff + 2'd1;
    end
  end

  assign status_w = {4'h0, wide_resolution_select, bw75, ns_active, active_ff};

  // ---------------- Per-channel data path ----------------
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    logic signed [DW-1:0] even_q;
    logic signed [DW-1:0] odd_q;
    logic signed [DW-1:0] hist_ff [ORDER_HI+1];
    logic signed [19:0] tap_sum;
    logic [DW-1:0] word_a_ff;
    logic [DW-1:0] word_b_ff;
    logic [NS_SHIFT-1:0] ns_err_ff;
    logic [PAIRS-1:0] pair_ff;
    logic clk_out_ff;

    core_stage u_even (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .sample_en(sample_en),
      .raw(ch_raw[ch].even),
      .cfg({core_gain_ff[2*ch][7:4], gain_common, filt_cfg_ff[BIT_OFFS_EN],
            test_sel_ff[2*ch], pat_hi_ff, pat_lo_ff}),
      .core_out_ff(even_q)
    );
    core_stage u_odd (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .sample_en(sample_en),
      .raw(ch_raw[ch].odd),
      .cfg({core_gain_ff[2*ch+1][7:4], gain_common, filt_cfg_ff[BIT_OFFS_EN],
            test_sel_ff[2*ch+1], pat_hi_ff, pat_lo_ff}),
      .core_out_ff(odd_q)
    );

    // Even core sample precedes odd in the interleaved history
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        for (int k = 0; k <= ORDER_HI; k++) hist_ff[k] <= '0;
      end else if (sample_d1_ff) begin
        hist_ff[0] <= odd_q;
        hist_ff[1] <= even_q;
        for (int k = 2; k <= ORDER_HI; k++) hist_ff[k] <= hist_ff[k-2];
      end
    end

    // Box taps keep the filter multiplier-free; high-pass flips alternate taps
    always_comb begin
      tap_sum = '0;
      for (int k = 0; k <= ORDER_HI; k++) begin
        if (6'(k) <= order_n) begin
          if (highpass && k[0]) tap_sum = tap_sum - 20'(hist_ff[k]);
          else tap_sum = tap_sum + 20'(hist_ff[k]);
        end
      end
    end

    wire logic [31:0] g_prod = filt_gain_q(filt_gain_ff[ch], bw75) * recip;
    wire logic signed [DW-1:0] filt_y = scale(tap_sum, g_prod[29:14]);
    wire logic signed [DW-1:0] ns_v = clip(40'(filt_y) + 40'(ns_err_ff));
    wire logic [DW-1:0] narrow_word = {{NS_SHIFT{1'b0}}, ns_v[DW-1:NS_SHIFT]};
    wire logic [DW-1:0] trunc_word = {{NS_SHIFT{1'b0}}, filt_y[DW-1:NS_SHIFT]};
    wire logic [DW-1:0] nxt_word_a =
      wide_resolution_select ? filt_y : (ns_active ? narrow_word : trunc_word);

    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        word_a_ff <= '0;
        word_b_ff <= '0;
        ns_err_ff <= '0;
      end else if (sample_d2_ff) begin
        if (bypass) begin
          // Raw interleaved words, filter gain never applied
          word_a_ff <= wide_resolution_select ? hist_ff[1]
                       : {{NS_SHIFT{1'b0}}, hist_ff[1][DW-1:NS_SHIFT]};
          word_b_ff <= wide_resolution_select ? hist_ff[0]
                       : {{NS_SHIFT{1'b0}}, hist_ff[0][DW-1:NS_SHIFT]};
        end else begin
          word_a_ff <= nxt_word_a;
        end
        ns_err_ff <= ns_active ? ns_v[NS_SHIFT-1:0] : '0;
      end
    end

    // Each pair carries bit 2i while the clock is high and bit 2i+1 while low
    wire logic [DW-1:0] cur_word = phase_ff[1] ? word_b_ff : word_a_ff;
    wire logic [PAIRS-1:0] rise_bits;
    wire logic [PAIRS-1:0] fall_bits;
    for (genvar p = 0; p < PAIRS; p++) begin : g_pair
      assign rise_bits[p] = cur_word[2*p];
      assign fall_bits[p] = cur_word[2*p+1];
    end

    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        pair_ff <= '0;
        clk_out_ff <= 1'b0;
      end else begin
        // Lanes hold between words so a new word never shows before its clock
        if (active_ff) begin
          pair_ff <= phase_ff[0] ? fall_bits : rise_bits;
        end
        clk_out_ff <= active_ff & ~phase_ff[0];
      end
    end

    assign lvds_data[ch] = pair_ff;
    assign lvds_clk[ch] = clk_out_ff;
  end
endmodule : adc_channel_gain_filter_path
`default_nettype wire

// file: adc_path_checker.sv
// Port-level checks for the dual-channel gain and filter path
`timescale 1ns/1ps
`default_nettype none
module adc_path_checker
  import adc_path_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sample_en,
  input wire logic sclk,
  input wire logic sdout,
  input wire logic [CHANNELS-1:0][PAIRS-1:0] lvds_data,
  input wire logic [CHANNELS-1:0] lvds_clk
);
  logic [3:0] age_ff;
  logic [3:0] low_ff;
  // Ages saturate so a long idle gap never wraps into a legal window
  wire logic [3:0] nxt_age = sample_en ? 4'h1 : age_ff + {3'h0, age_ff != 4'hF};
  wire logic [3:0] nxt_low = !sclk ? 4'h0 : low_ff + {3'h0, low_ff != 4'hF};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      age_ff <= 4'hF;
      low_ff <= 4'hF;
    end else begin
      age_ff <= nxt_age;
      low_ff <= nxt_low;
    end
  end
  clk_pulse0_a: assert property (lvds_clk[0] |=> !lvds_clk[0])
    else $error("lane 0 clock high two cycles");
  clk_pulse1_a: assert property (lvds_clk[1] |=> !lvds_clk[1])
    else $error("lane 1 clock high two cycles");
  clk_align_a: assert property (lvds_clk[0] == lvds_clk[1])
    else $error("channel clocks disagree");
  word_launch_a: assert property (sample_en |-> ##[5:6] (lvds_clk[0] && lvds_clk[1]))
    else $error("no word after sample");
  clk_cause_a: assert property (lvds_clk[0] |-> age_ff inside {[4'h5:4'h8]})
    else $error("output clock without sample");
  data_hold_a: assert property (!$stable(lvds_data) |-> age_ff inside {[4'h5:4'h9]})
    else $error("lane data moved outside a word");
  word_pair_a: assert property (lvds_clk[0] && age_ff > 4'h6 |-> $past(lvds_clk[0], 2))
    else $error("second word without first");
  sdout_quiet_a: assert property ($changed(sdout) |-> low_ff < 4'h9)
    else $error("read data moved without serial clock");
  cover property (lvds_clk[0] ##2 lvds_clk[0]);
  cover property (sample_en ##[5:6] lvds_clk[0]);
  cover property ($changed(sdout));
endmodule : adc_path_checker

bind adc_channel_gain_filter_path adc_path_checker #(.CHANNELS(CHANNELS)) adc_path_checker_i (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .sample_en(sample_en),
  .sclk(sclk),
  .sdout(sdout),
  .lvds_data(lvds_data),
  .lvds_clk(lvds_clk)
);
`default_nettype wire

// file: lvds_capture_model.sv
// Receiving logic that rebuilds each channel word from the DDR lane pairs
`timescale 1ns/1ps
`default_nettype none
module lvds_capture_model
  import adc_path_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0][PAIRS-1:0] lvds_data,
  input wire logic [1:0] lvds_clk,
  output logic [1:0][DW-1:0] last_word,
  output logic [1:0][DW-1:0] prev_word
);
  logic [1:0][PAIRS-1:0] rise_ff;
  logic [1:0] pend_ff;
  always @(posedge clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      pend_ff[c] <= lvds_clk[c] && !sys_rst;
      if (lvds_clk[c]) rise_ff[c] <= lvds_data[c];
      if (pend_ff[c]) begin
        prev_word[c] <= last_word[c];
        for (int p = 0; p < PAIRS; p++) begin
          last_word[c][2*p] <= rise_ff[c][p];
          last_word[c][2*p+1] <= lvds_data[c][p];
        end
      end
    end
  end
endmodule : lvds_capture_model
`default_nettype wire

// file: tb_adc_channel_gain_filter_path.sv
// Self-checking bench for the dual-channel gain and filter path
`timescale 1ns/1ps
`default_nettype none
module tb_adc_channel_gain_filter_path;
  import adc_path_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic sample_en = 1'b0;
  core_pair_t [1:0] ch_raw = '0;
  logic sclk = 1'b1;
  logic sen_n = 1'b1;
  logic sdata = 1'b0;
  logic ns_pin = 1'b0;
  logic bw_pin = 1'b0;
  wire logic sdout;
  wire logic [1:0][PAIRS-1:0] lvds_data;
  wire logic [1:0] lvds_clk;
  wire logic [1:0][DW-1:0] last_w;
  wire logic [1:0][DW-1:0] prev_w;
  int err_count = 0;
  int num_checks = 0;
  logic [7:0] q;

  adc_channel_gain_filter_path #(.CHANNELS(2)) adc_channel_gain_filter_path_i (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sample_en(sample_en),
    .ch_raw(ch_raw),
    .sclk(sclk),
    .sen_n(sen_n),
    .sdata(sdata),
    .sdout(sdout),
    .noise_shape_en_pin(ns_pin),
    .noise_bw75_pin(bw_pin),
    .lvds_data(lvds_data),
    .lvds_clk(lvds_clk)
  );
  lvds_capture_model lvds_capture_model_i (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .lvds_data(lvds_data),
    .lvds_clk(lvds_clk),
    .last_word(last_w),
    .prev_word(prev_w)
  );

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Gains are rounded in hardware, so allow a few codes plus one percent
  task automatic near(input string what, input real exp, input logic [13:0] got, input bit mag);
    real v;
    v = $itor($signed(got));
    if (mag && v < 0.0) v = -v;
    num_checks++;
    if ($isunknown(got) || (v - exp) ** 2 > (3.0 + exp / 100.0) ** 2) begin
      err_count++;
      $display("mismatch %s expected %0.1f seen %0.1f", what, exp, v);
    end
  endtask : near

  // Serial clock halves of four system cycles give the 80 ns link period
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {a, d};
    sen_n <= 1'b0;
    tick(4);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      sdata <= w[i];
      tick(4);
      sclk <= 1'b1;
      tick(4);
      // Read data moved on the edge after the fall was seen; it stands here
      q = {q[6:0], sdout};
    end
    sen_n <= 1'b1;
    tick(8);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wr(8'h00, 8'h01);
    wr(a, 8'h00);
    check($sformatf("reg %h", a), {6'h00, exp}, {6'h00, q});
    wr(8'h00, 8'h00);
  endtask : rd

  task automatic samp(input int e1, input int o1, input int e2, input int o2);
    ch_raw[0] <= {14'(e1), 14'(o1)};
    ch_raw[1] <= {14'(e2), 14'(o2)};
    sample_en <= 1'b1;
    tick(1);
    sample_en <= 1'b0;
    tick(11);
  endtask : samp

  task automatic settle(input int e, input int o);
    repeat (12) samp(e, o, e, o);
  endtask : settle

  task automatic t_regs;
    logic [7:0] a [10] = '{8'h25, 8'h2B, 8'h2C, 8'h31, 8'h32, 8'h37, 8'h42, 8'h44, 8'h60, 8'hF3};
    foreach (a[i]) rd(a[i], 8'h00);
    wr(8'h25, 8'hC0);
    wr(8'h2C, 8'h54);
    wr(8'h10, 8'hFF);
    wr(8'h00, 8'h01);
    wr(8'h2C, 8'h44);
    wr(8'h00, 8'h00);
    rd(8'h2C, 8'h54);
    rd(8'h25, 8'hC0);
    rd(8'h10, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_bypass;
    wr(8'h3F, 8'h2A);
    wr(8'h40, 8'h5C);
    wr(8'h61, 8'h01);
    wr(8'h44, 8'h02);
    wr(8'hF3, 8'h08);
    samp(100, 1000, -300, 700);
    check("ch1 word a", 14'h2A5C, prev_w[0]);
    check("ch1 word b", 14'h03E8, last_w[0]);
    check("ch2 word a", 14'h3ED4, prev_w[1]);
    check("ch2 word b", 14'h02BC, last_w[1]);
    wr(8'h42, 8'h08);
    samp(100, 1000, -300, 700);
    near("ch1 odd gain", 1995.3, last_w[0], 1'b0);
    wr(8'hF3, 8'h00);
    samp(100, 1000, -300, 700);
    check("ch2 narrow word", 14'h01F6, prev_w[1]);
    wr(8'h42, 8'h00);
    wr(8'h61, 8'h00);
    wr(8'h44, 8'h00);
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_filter;
    logic [7:0] code [12] = '{8'h04, 8'h0C, 8'h14, 8'h1C, 8'h24, 8'h2C, 8'h34, 8'h3C,
      8'h44, 8'h4C, 8'h54, 8'h00};
    real db [12] = '{-3.1, -2.1, -1.5, -1.0, -0.5, 0.0, 0.5, 1.0, 1.5, 2.0, 3.0, 1.6};
    wr(8'hF3, 8'h08);
    for (int i = 0; i < 12; i++) begin
      wr(8'h2C, code[i]);
      settle(1000, 1000);
      near("ch1 filter gain", 1000.0 * 10.0 ** (db[i] / 20.0), last_w[0], 1'b0);
    end
    near("ch2 default gain", 1202.3, last_w[1], 1'b0);
    settle(1000, -1000);
    near("low-pass 12th", 92.5, last_w[0], 1'b1);
    wr(8'h60, 8'h02);
    settle(1000, -1000);
    near("low-pass 20th", 57.3, last_w[0], 1'b1);
    wr(8'h60, 8'h03);
    settle(1000, -1000);
    near("high-pass", 1202.3, last_w[0], 1'b1);
    wr(8'h60, 8'h00);
    $display("test filter done");
  endtask : t_filter

  task automatic t_status;
    ns_pin <= 1'b1;
    wr(8'hF3, 8'h00);
    rd(8'h62, 8'h02);
    wr(8'hF3, 8'h08);
    bw_pin <= 1'b1;
    rd(8'h62, 8'h0C);
    settle(1000, 1000);
    near("bw75 default gain", 1244.5, last_w[0], 1'b0);
    ns_pin <= 1'b0;
    bw_pin <= 1'b0;
    $display("test status done");
  endtask : t_status

  task automatic t_sum;
    foreach (REG_CORE_GAIN[i]) wr(REG_CORE_GAIN[i], 8'h20);
    wr(8'h42, 8'h08);
    wr(8'h2C, 8'h3C);
    settle(1000, 1000);
    near("ch1 summed gain", 1258.9, last_w[0], 1'b0);
    near("ch2 summed gain", 1349.0, last_w[1], 1'b0);
    $display("test sum done");
  endtask : t_sum

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  initial begin
    tick(80000);
    err_count++;
    $display("mismatch watchdog expected finish seen timeout");
    close_out();
  end

  initial begin
    tick(2);
    sys_rst <= 1'b0;
    tick(4);
    t_regs();
    t_bypass();
    t_filter();
    t_status();
    t_sum();
    close_out();
  end
endmodule : tb_adc_channel_gain_filter_path
`default_nettype wire
